// ==== hdl/cis_pkg.sv ====
// Constants and types shared by the instruction sequencer.
package cis_pkg;

  // Machine cycle kinds; each one is announced in a status byte.
  typedef enum logic [3:0] {
    CIS_MC_FETCH  = 4'h0,
    CIS_MC_MREAD  = 4'h1,
    CIS_MC_MWRITE = 4'h2,
    CIS_MC_SREAD  = 4'h3,
    CIS_MC_SWRITE = 4'h4,
    CIS_MC_IORD   = 4'h5,
    CIS_MC_IOWR   = 4'h6,
    CIS_MC_INTACK = 4'h7,
    CIS_MC_NONE   = 4'h8
  } cis_mc_t;

  // Status byte bit positions.
  localparam int CIS_ST_INTERRUPT_ACK_INDICATION  = 0;
  localparam int CIS_ST_WO    = 1;
  localparam int CIS_ST_STACK = 2;
  localparam int CIS_ST_OUT   = 4;
  localparam int CIS_ST_M1    = 5;
  localparam int CIS_ST_INP   = 6;
  localparam int CIS_ST_MEMR  = 7;

  // Clock states per machine cycle and machine cycles per instruction.
  localparam logic [2:0] CIS_T_SHORT = 3'h3;
  localparam logic [2:0] CIS_T_FETCH4 = 3'h4;
  localparam logic [2:0] CIS_T_FETCH5 = 3'h5;
  localparam logic [2:0] CIS_M_MAX = 3'h5;

  // Flag word bit positions.
  localparam int CIS_F_CARRY = 0;
  localparam int CIS_F_SUB   = 1;
  localparam int CIS_F_PAR   = 2;
  localparam int CIS_F_HALF  = 4;
  localparam int CIS_F_ZERO  = 6;
  localparam int CIS_F_SIGN  = 7;
  localparam logic [7:0] CIS_FLAGS_RST = 8'h00;

  // Register field codes.
  localparam logic [2:0] CIS_R_MEM = 3'h6;
  localparam logic [2:0] CIS_R_ACC = 3'h7;

endpackage

// ==== hdl/cis_flag_unit.sv ====
// Flag update unit for arithmetic, logic, rotate and decimal adjust results.
`timescale 1ns/1ps
module cis_flag_unit
  import cis_pkg::*;
(
  // Operation select.
  input  wire logic [2:0] alu_op_i,
  input  wire logic       rot_i,
  input  wire logic [1:0] rot_kind_i,
  input  wire logic       daa_i,
  // Operands and present flags.
  input  wire logic [7:0] acc_i,
  input  wire logic [7:0] opnd_i,
  input  wire logic [7:0] flags_i,
  // Result.
  output logic      [7:0] res_o,
  output logic      [7:0] flags_o
);

  logic [8:0] sum;
  logic [4:0] low;
  logic       cin;
  logic       is_sub;
  logic [7:0] corr;

  // One adder serves add and subtract; the low nibble sum gives the half carry.
  always_comb begin
    cin     = alu_op_i[0] & ~alu_op_i[2] & flags_i[CIS_F_CARRY]; // Compare takes no borrow in.
    is_sub  = (alu_op_i == 3'h2) | (alu_op_i == 3'h3) | (alu_op_i == 3'h7);
    corr    = 8'h00;
    flags_o = flags_i;
    res_o   = acc_i;
    sum     = 9'h000;
    low     = 5'h00;
    if (daa_i) begin
      // Correction sign follows the subtract flag so BCD subtraction works.
      if (flags_i[CIS_F_HALF] | (acc_i[3:0] > 4'h9)) corr[3:0] = 4'h6;
      if (flags_i[CIS_F_CARRY] | (acc_i > 8'h99)) corr[7:4] = 4'h6;
      if (flags_i[CIS_F_SUB]) begin
        sum = {1'b0, acc_i} - {1'b0, corr};
        low = {1'b0, acc_i[3:0]} - {1'b0, corr[3:0]};
      end else begin
        sum = {1'b0, acc_i} + {1'b0, corr};
        low = {1'b0, acc_i[3:0]} + {1'b0, corr[3:0]};
      end
      res_o = sum[7:0];
      flags_o[CIS_F_CARRY] = flags_i[CIS_F_CARRY] | (corr[7:4] != 4'h0);
      flags_o[CIS_F_HALF]  = low[4];
    end else if (rot_i) begin
      // Plain rotates wrap bit into carry; through-carry forms rotate 9 bits.
      case (rot_kind_i)
        2'h0: begin
          res_o = {acc_i[6:0], acc_i[7]};
          flags_o[CIS_F_CARRY] = acc_i[7];
        end
        2'h1: begin
          res_o = {acc_i[0], acc_i[7:1]};
          flags_o[CIS_F_CARRY] = acc_i[0];
        end
        2'h2: begin
          res_o = {acc_i[6:0], flags_i[CIS_F_CARRY]};
          flags_o[CIS_F_CARRY] = acc_i[7];
        end
        default: begin
          res_o = {flags_i[CIS_F_CARRY], acc_i[7:1]};
          flags_o[CIS_F_CARRY] = acc_i[0];
        end
      endcase
    end else begin
      case (alu_op_i)
        3'h4: res_o = acc_i & opnd_i;
        3'h5: res_o = acc_i ^ opnd_i;
        3'h6: res_o = acc_i | opnd_i;
        default: begin
          if (is_sub) begin
            sum = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, cin};
            low = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, cin};
          end else begin
            sum = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
            low = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
          end
          res_o = (alu_op_i == 3'h7) ? acc_i : sum[7:0];
        end
      endcase
      if (alu_op_i[2:1] == 2'h2 || alu_op_i == 3'h6) begin
        // Logic ops clear carry but leave the hidden flags alone.
        flags_o[CIS_F_CARRY] = 1'b0;
      end else begin
        flags_o[CIS_F_CARRY] = sum[8];
        flags_o[CIS_F_HALF]  = low[4];
        flags_o[CIS_F_SUB]   = is_sub;
      end
      flags_o[CIS_F_SIGN] = ((alu_op_i == 3'h7) ? sum[7] : res_o[7]);
      flags_o[CIS_F_ZERO] = ((alu_op_i == 3'h7) ? sum[7:0] : res_o) == 8'h00;
      flags_o[CIS_F_PAR]  = ~^((alu_op_i == 3'h7) ? sum[7:0] : res_o);
    end
  end

endmodule

// ==== hdl/cis_cycle_plan.sv ====
// Opcode decoder that gives the machine cycle plan of an instruction.
`timescale 1ns/1ps
module cis_cycle_plan
  import cis_pkg::*;
(
  // Opcode and condition result.
  input  wire logic [7:0] op_i,
  input  wire logic       cond_i,
  // Plan: machine cycle count, fetch length, and kind of each later cycle.
  output logic      [2:0] n_mc_o,
  output logic      [2:0] t_fetch_o,
  output logic      [1:0] n_bytes_o,
  output cis_mc_t         mc_kind_o [2:5]
);

  // Fills the plan for cycles 2 to 5 from one table row.
  always_comb begin
    n_mc_o    = 3'h1;
    t_fetch_o = CIS_T_FETCH4;
    n_bytes_o = 2'h1;
    for (int i = 2; i <= 5; i++) mc_kind_o[i] = CIS_MC_NONE;
    casez (op_i)
      8'b11??0101, 8'b11000111, 8'b11??1111, 8'b11??0111: begin
        // Push and restart: five-state fetch, two stack writes.
        t_fetch_o = CIS_T_FETCH5;
        n_mc_o = 3'h3;
        mc_kind_o[2] = CIS_MC_SWRITE;
        mc_kind_o[3] = CIS_MC_SWRITE;
      end
      8'b11001101, 8'b11???100: begin
        t_fetch_o = CIS_T_FETCH5;
        n_bytes_o = 2'h3;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MREAD;
        mc_kind_o[4] = CIS_MC_SWRITE;
        mc_kind_o[5] = CIS_MC_SWRITE;
        n_mc_o = (op_i[0] | cond_i) ? 3'h5 : 3'h3;
      end
      8'b11001001, 8'b11???000: begin
        t_fetch_o = CIS_T_FETCH5;
        mc_kind_o[2] = CIS_MC_SREAD;
        mc_kind_o[3] = CIS_MC_SREAD;
        n_mc_o = (op_i[0] | cond_i) ? 3'h3 : 3'h1;
      end
      8'b11100011: begin
        t_fetch_o = CIS_T_FETCH5;
        n_mc_o = 3'h5;
        mc_kind_o[2] = CIS_MC_SREAD;
        mc_kind_o[3] = CIS_MC_SREAD;
        mc_kind_o[4] = CIS_MC_SWRITE;
        mc_kind_o[5] = CIS_MC_SWRITE;
      end
      8'b00??1001: begin
        // Double add runs two idle cycles on the bus.
        t_fetch_o = CIS_T_FETCH5;
        n_mc_o = 3'h3;
        mc_kind_o[2] = CIS_MC_NONE;
        mc_kind_o[3] = CIS_MC_NONE;
      end
      8'b00110100, 8'b00110101: begin
        n_mc_o = 3'h3;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MWRITE;
      end
      8'b00???10?, 8'b00???011, 8'b11101001: begin
        t_fetch_o = CIS_T_FETCH5;
      end
      8'b11000011, 8'b11???010, 8'b00??0001: begin
        n_mc_o = 3'h3;
        n_bytes_o = 2'h3;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MREAD;
      end
      8'b11??0001: begin
        n_mc_o = 3'h3;
        mc_kind_o[2] = CIS_MC_SREAD;
        mc_kind_o[3] = CIS_MC_SREAD;
      end
      8'b0011?010: begin
        n_mc_o = 3'h4;
        n_bytes_o = 2'h3;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MREAD;
        mc_kind_o[4] = op_i[3] ? CIS_MC_MREAD : CIS_MC_MWRITE;
      end
      8'b0010?010: begin
        n_mc_o = 3'h5;
        n_bytes_o = 2'h3;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MREAD;
        mc_kind_o[4] = op_i[3] ? CIS_MC_MREAD : CIS_MC_MWRITE;
        mc_kind_o[5] = op_i[3] ? CIS_MC_MREAD : CIS_MC_MWRITE;
      end
      8'b000??010: begin
        n_mc_o = 3'h2;
        mc_kind_o[2] = op_i[3] ? CIS_MC_MREAD : CIS_MC_MWRITE;
      end
      8'b1101?011: begin
        n_mc_o = 3'h3;
        n_bytes_o = 2'h2;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = op_i[3] ? CIS_MC_IORD : CIS_MC_IOWR;
      end
      8'b00110110: begin
        n_mc_o = 3'h3;
        n_bytes_o = 2'h2;
        mc_kind_o[2] = CIS_MC_MREAD;
        mc_kind_o[3] = CIS_MC_MWRITE;
      end
      8'b00???110, 8'b11???110: begin
        n_mc_o = 3'h2;
        n_bytes_o = 2'h2;
        mc_kind_o[2] = CIS_MC_MREAD;
      end
      8'b01110???, 8'b01???110, 8'b10???110: begin
        // Register field 110 means memory through the address pair.
        if (op_i != 8'h76) begin
          n_mc_o = 3'h2;
          mc_kind_o[2] = (op_i[7:3] == 5'b01110) ? CIS_MC_MWRITE : CIS_MC_MREAD;
        end else begin
          n_mc_o = 3'h2;
          mc_kind_o[2] = CIS_MC_NONE;
        end
      end
      default: begin
        n_mc_o = 3'h1;
      end
    endcase
  end

endmodule

// ==== hdl/cis_sequencer.sv ====
// Machine cycle and clock state sequencer of the 8-bit core.
`timescale 1ns/1ps
module cis_sequencer
  import cis_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Data bus.
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  // Bus strobes and cycle information.
  output logic            sync_o,
  output logic            read_o,
  output logic            write_o,
  output logic [7:0]      status_o,
  output logic [2:0]      mcycle_o,
  output logic [2:0]      tstate_o,
  output logic [15:0]     addr_o,
  // Interrupt request and acknowledge.
  input  wire logic       irq_i,
  output logic            interrupt_ack_indication_o,
  // Processor state visible to the system.
  output logic [7:0]      acc_o,
  output logic [7:0]      flags_o,
  output logic [7:0]      opcode_o,
  output logic            instr_done_o
);

  // Sequencer state.
  logic [2:0]  mc;
  logic [2:0]  ts;
  logic [7:0]  op;
  logic [7:0]  b2;
  logic [7:0]  acc;
  logic [7:0]  flags;
  logic [15:0] pc;
  logic [15:0] sp;
  logic [15:0] address_register_pair;
  logic        ack;
  logic        done;
  logic [7:0]  dout;
  logic [2:0]  next_mc;
  logic [2:0]  next_ts;
  logic [7:0]  next_op;
  logic [7:0]  next_b2;
  logic [7:0]  next_acc;
  logic [7:0]  next_flags;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [15:0] next_pair;
  logic        next_ack;
  logic        next_done;
  logic [7:0]  next_dout;
  logic [7:0]  data_b3;
  logic [7:0]  next_b3;

  // Plan and flag unit results.
  logic [2:0]  n_mc;
  logic [2:0]  t_fetch;
  logic [1:0]  n_bytes;
  cis_mc_t     kinds [2:5];
  cis_mc_t     cur_kind;
  logic        cond;
  logic [7:0]  alu_res;
  logic [7:0]  alu_flags;
  logic [2:0]  t_last;
  logic        fetching;
  logic        rot_sel;
  logic        is_call;

  // Condition test on the testable flags, picked by opcode bits 5:3.
  function automatic logic cond_true(input logic [2:0] cc, input logic [7:0] f);
    logic v;
    v = 1'b0;
    case (cc[2:1])
      2'h0: v = f[CIS_F_ZERO];
      2'h1: v = f[CIS_F_CARRY];
      2'h2: v = f[CIS_F_PAR];
      default: v = f[CIS_F_SIGN];
    endcase
    return v == cc[0];
  endfunction

  // Status byte for a machine cycle kind.
  function automatic logic [7:0] status_of(input cis_mc_t k, input logic a);
    logic [7:0] s;
    s = 8'h00;
    s[CIS_ST_WO] = 1'b1;
    case (k)
      CIS_MC_FETCH:  begin s[CIS_ST_M1] = 1'b1; s[CIS_ST_MEMR] = ~a; end
      CIS_MC_MREAD:  s[CIS_ST_MEMR] = ~a;
      CIS_MC_MWRITE: s[CIS_ST_WO] = 1'b0;
      CIS_MC_SREAD:  begin s[CIS_ST_STACK] = 1'b1; s[CIS_ST_MEMR] = 1'b1; end
      CIS_MC_SWRITE: begin s[CIS_ST_STACK] = 1'b1; s[CIS_ST_WO] = 1'b0; end
      CIS_MC_IORD:   s[CIS_ST_INP] = 1'b1;
      CIS_MC_IOWR:   begin s[CIS_ST_OUT] = 1'b1; s[CIS_ST_WO] = 1'b0; end
      default:       s = 8'h02;
    endcase
    s[CIS_ST_INTERRUPT_ACK_INDICATION] = a;
    return s;
  endfunction

  assign cond = cond_true(op[5:3], flags);

  cis_cycle_plan u_plan (
    .op_i      (op),
    .cond_i    (cond),
    .n_mc_o    (n_mc),
    .t_fetch_o (t_fetch),
    .n_bytes_o (n_bytes),
    .mc_kind_o (kinds)
  );

  // The operand is taken straight off the bus in the closing read state, because b2 only
  // lands on that same edge and would still hold the previous byte.
  cis_flag_unit u_flags (
    .alu_op_i   (op[5:3]),
    .rot_i      (rot_sel),
    .rot_kind_i (op[4:3]),
    .daa_i      (op == 8'h27),
    .acc_i      (acc),
    .opnd_i     (data_i),
    .flags_i    (flags),
    .res_o      (alu_res),
    .flags_o    (alu_flags)
  );

  // Plain and through-carry rotates; calls and restarts push the program counter.
  assign rot_sel = (op[7:5] == 3'h0) && (op[2:0] == 3'h7) && ~op[5];
  assign is_call = (op == 8'hCD) ||
                   (op[7:6] == 2'h3 && (op[2:0] == 3'h4 || op[2:0] == 3'h7));

  // Fetch cycles are the first ones, up to the instruction length.
  always_comb begin
    fetching = (mc == 3'h1) || (mc <= {1'b0, n_bytes});
    if (mc == 3'h1) cur_kind = ack ? CIS_MC_INTACK : CIS_MC_FETCH;
    else if (fetching) cur_kind = CIS_MC_MREAD;
    else cur_kind = kinds[mc];
    t_last = (mc == 3'h1) ? t_fetch : CIS_T_SHORT;
  end

  // Bus strobes follow the clock state; status only in the first state.
  assign sync_o     = (ts == 3'h1);
  assign status_o   = status_of(cur_kind, ack);
  assign read_o     = (ts == 3'h2 || ts == 3'h3) && cur_kind != CIS_MC_NONE &&
                      ~status_o[CIS_ST_WO] == 1'b0;
  assign write_o    = (ts == 3'h3) && ~status_o[CIS_ST_WO] && cur_kind != CIS_MC_NONE;
  assign data_oe_o  = sync_o | write_o;
  assign data_o     = sync_o ? status_o : dout;
  assign mcycle_o   = mc;
  assign tstate_o   = ts;
  assign acc_o      = acc;
  assign flags_o    = flags;
  assign opcode_o   = op;
  assign instr_done_o = done;
  assign interrupt_ack_indication_o = ack;
  assign addr_o = (cur_kind == CIS_MC_SREAD || cur_kind == CIS_MC_SWRITE) ? sp :
                  (cur_kind == CIS_MC_IORD || cur_kind == CIS_MC_IOWR) ? {b2, b2} :
                  (kinds[mc] == CIS_MC_MREAD || kinds[mc] == CIS_MC_MWRITE) && ~fetching &&
                  op[7:6] == 2'h0 && op[2:0] == 3'h2 && op[5] ? {data_b3, b2} :
                  (~fetching && op[7:6] != 2'h3) ? address_register_pair : pc;

  // Next state of the sequencer and the architectural registers.
  always_comb begin
    next_mc = mc;
    next_ts = ts + 3'h1;
    next_op = op;
    next_b2 = b2;
    next_b3 = data_b3;
    next_acc = acc;
    next_flags = flags;
    next_pc = pc;
    next_sp = sp;
    next_pair = address_register_pair;
    next_ack = ack;
    next_done = 1'b0;
    next_dout = dout;
    if (ts == 3'h3 && cur_kind != CIS_MC_NONE && ~write_o) begin
      // Byte taken in the third state of a read cycle.
      if (mc == 3'h1) next_op = data_i;
      else if (mc == 3'h2) next_b2 = data_i;
      else if (mc == 3'h3 && fetching) next_b3 = data_i;
      if (fetching && !ack) next_pc = pc + 16'h0001;
    end
    if (ts == 3'h2 && cur_kind == CIS_MC_SWRITE) next_sp = sp - 16'h0001;
    // Write data is loaded one state early so that it stands through the T3 strobe.
    if (ts == 3'h2 && ~status_o[CIS_ST_WO]) begin
      if (is_call) next_dout = mc[0] ? pc[7:0] : pc[15:8];
      else if (cur_kind == CIS_MC_SWRITE) next_dout = mc[0] ? flags : acc;
      else next_dout = acc;
    end
    if (ts == 3'h3 && cur_kind == CIS_MC_SREAD) next_sp = sp + 16'h0001;
    if (ts >= t_last) begin
      next_ts = 3'h1;
      next_mc = mc + 3'h1;
      if (mc >= n_mc || mc == CIS_M_MAX) begin
        next_mc = 3'h1;
        next_done = 1'b1;
        if (op[7:6] == 2'h2 || op[7:6] == 2'h3 && op[2:0] == 3'h6 ||
            op == 8'h27 || rot_sel) begin
          next_acc = (op[5:3] == 3'h7 && op[7]) ? acc : alu_res;
          next_flags = alu_flags;
        end
        // Loads that end on a read take their byte from the bus at this edge.
        if (op == 8'h3E || op == 8'h3A || op == 8'hDB) next_acc = data_i;
        if (op == 8'h21) next_pair = {data_i, b2};
        if (op == 8'hE9) next_pc = address_register_pair;
        // Jumps and returns end in the high byte read; a taken call ends after its pushes.
        if (mc == 3'h3 && (op == 8'hC3 || op == 8'hC9 ||
            (op[7:6] == 2'h3 && (op[2:0] == 3'h2 || op[2:0] == 3'h0) && cond))) begin
          next_pc = {data_i, b2};
        end
        if (mc == 3'h5 && is_call) next_pc = {data_b3, b2};
        if (op[7:6] == 2'h0 && op[3:0] == 4'h9) begin
          // Only the pair itself and the stack pointer are kept; other pairs add as zero.
          {next_flags[CIS_F_CARRY], next_pair} = {1'b0, address_register_pair} +
            {1'b0, (op[5:4] == 2'h2) ? address_register_pair :
                   (op[5:4] == 2'h3) ? sp : 16'h0000};
        end
        // Held acknowledge covers the whole call fetch sequence.
        next_ack = irq_i & ~ack;
      end else if (ack && mc == {1'b0, n_bytes}) begin
        next_ack = 1'b0;
      end
    end
  end

  // Register stage.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mc <= 3'h1;
      ts <= 3'h1;
      op <= 8'h00;
      b2 <= 8'h00;
      data_b3 <= 8'h00;
      acc <= 8'h00;
      flags <= CIS_FLAGS_RST;
      pc <= 16'h0000;
      sp <= 16'h0000;
      address_register_pair <= 16'h0000;
      ack <= 1'b0;
      done <= 1'b0;
      dout <= 8'h00;
    end else begin
      mc <= next_mc;
      ts <= next_ts;
      op <= next_op;
      b2 <= next_b2;
      data_b3 <= next_b3;
      acc <= next_acc;
      flags <= next_flags;
      pc <= next_pc;
      sp <= next_sp;
      address_register_pair <= next_pair;
      ack <= next_ack;
      done <= next_done;
      dout <= next_dout;
    end
  end

  // Checks on the sequence.
  a_tstate_range: assert property (@(posedge clk_i) disable iff (rst_i)
    ts >= 3'h1 && ts <= 3'h5) else $error("clock state out of range");
  a_mcycle_range: assert property (@(posedge clk_i) disable iff (rst_i)
    mc >= 3'h1 && mc <= 3'h5) else $error("machine cycle out of range");
  a_sync_first: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_o |-> data_oe_o && data_o == status_o) else $error("status missing");
  a_sync_once: assert property (@(posedge clk_i) disable iff (rst_i)
    sync_o |=> !sync_o) else $error("sync too long");
  a_done_new: assert property (@(posedge clk_i) disable iff (rst_i)
    done |-> mc == 3'h1 && ts == 3'h1) else $error("done off boundary");
  a_logic_hidden: assert property (@(posedge clk_i) disable iff (rst_i)
    done && $past(op[7] && op[5:3] inside {3'h4, 3'h5, 3'h6} && (!op[6] || op[2:0] == 3'h6))
    |-> flags[CIS_F_HALF] == $past(flags[CIS_F_HALF], 2) &&
    flags[CIS_F_SUB] == $past(flags[CIS_F_SUB], 2)) else $error("hidden flag hit");
  a_no_write_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    cur_kind == CIS_MC_NONE |-> !write_o) else $error("idle cycle wrote");
  a_fetch_short: assert property (@(posedge clk_i) disable iff (rst_i)
    mc != 3'h1 |-> ts <= 3'h3) else $error("long non-fetch cycle");
  c_ack_cycle: cover property (@(posedge clk_i) disable iff (rst_i) ack && mc == 3'h3);
  c_five_mc: cover property (@(posedge clk_i) disable iff (rst_i) mc == 3'h5);
  c_io_cycle: cover property (@(posedge clk_i) disable iff (rst_i) cur_kind == CIS_MC_IORD);

endmodule

// ==== sim/cis_bus_partner.sv ====
// Bus partner: program and data memory, I/O ports and interrupting controller.
`timescale 1ns/1ps
module cis_bus_partner
  import cis_pkg::*;
(
  // Clock and bus from the sequencer.
  input  wire logic        clk_i,
  input  wire logic        sync_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic        oe_i,
  input  wire logic        ack_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  data_i,
  // Read data towards the sequencer.
  output logic      [7:0]  data_o
);
  logic [7:0] mem [0:4095];
  logic [7:0] vec [0:2];
  logic [7:0] st = 8'h00;
  logic [7:0] last = 8'h00;
  logic [1:0] vidx = 2'h0;
  logic       was_ack = 1'b0;
  logic [7:0] answer;

  // Status is kept from the sync state; the controller byte index moves once per cycle.
  always @(posedge clk_i) begin
    last <= data_o;
    if (sync_i) begin
      st <= status_i;
      was_ack <= ack_i;
      if (ack_i && was_ack) vidx <= vidx + 2'h1;
    end
    if (!ack_i) vidx <= 2'h0;
    if (write_i && oe_i && !st[CIS_ST_OUT]) mem[addr_i[11:0]] <= data_i;
  end

  // Controller bytes win while acknowledged; a port answers with its inverted number.
  always_comb begin
    if (ack_i) answer = vec[vidx];
    else if (st[CIS_ST_INP]) answer = ~addr_i[7:0];
    else answer = mem[addr_i[11:0]];
  end

  // A released bus shows the inverse of its last value, so a stale sample cannot pass.
  assign data_o = read_i ? answer : ~last;
endmodule

// ==== sim/cis_sequencer_bench.sv ====
// Self-checking bench: instruction timing, accumulator and flag results, interrupt entry.
`timescale 1ns/1ps
module cis_sequencer_bench;
  import cis_pkg::*;
  typedef struct {int st; int acks; logic ck; logic [7:0] acc; logic [7:0] msk;
                  logic [7:0] flg;} cis_note_t;
  localparam logic [7:0] FC = 8'h01 << CIS_F_CARRY;
  localparam logic [7:0] FH = 8'h01 << CIS_F_HALF;
  localparam logic [7:0] FS = 8'h01 << CIS_F_SUB;
  logic        clk_i, rst_i, irq_i, sync, rd, wr, oe, ack, done;
  logic [7:0]  bus_data, dut_data, status, acc, flags, a, b, d, p, r1, r2;
  logic [15:0] addr, w;
  logic [8:0]  s, s2;
  logic [4:0]  h;
  int          failures, comparisons, pc, cnt, acks, k, lxp;
  bit          started;
  cis_note_t   q[$], n;

  cis_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .data_i(bus_data), .data_o(dut_data),
    .data_oe_o(oe), .sync_o(sync), .read_o(rd), .write_o(wr), .status_o(status),
    .mcycle_o(), .tstate_o(), .addr_o(addr), .irq_i(irq_i),
    .interrupt_ack_indication_o(ack), .acc_o(acc), .flags_o(flags), .opcode_o(),
    .instr_done_o(done));
  cis_bus_partner bus (.clk_i(clk_i), .sync_i(sync), .read_i(rd), .write_i(wr), .oe_i(oe),
    .ack_i(ack), .status_i(status), .addr_i(addr), .data_i(dut_data), .data_o(bus_data));

  // Free-running clock of 40 ns.
  always #20 clk_i = ~clk_i;

  function automatic logic [7:0] mkf(input logic c, input logic hc, input logic sb);
    mkf = 8'h00;
    mkf[CIS_F_CARRY] = c;
    mkf[CIS_F_HALF] = hc;
    mkf[CIS_F_SUB] = sb;
  endfunction

  task automatic fail(input string msg);
    $display("unexpected at %0t: %s", $time, msg);
    failures++;
  endtask

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp, input string msg);
    comparisons++;
    if (got !== exp) fail(msg);
  endtask

  task automatic chk_n(input int got, input int exp, input string msg);
    comparisons++;
    if (got != exp) fail(msg);
  endtask

  task automatic put(input logic [7:0] v);
    bus.mem[pc] = v;
    pc++;
  endtask

  // A checked result is followed by a filler fetch, so it is compared once it has landed.
  task automatic op(input int nb, input logic [23:0] code, input int st, input logic ck = 1'b0,
                    input logic [7:0] ea = 8'h00, input logic [7:0] m = 8'h00,
                    input logic [7:0] f = 8'h00);
    for (int i = 0; i < nb; i++) put(code[8*i +: 8]);
    q.push_back('{st, 0, 1'b0, 8'h00, 8'h00, 8'h00});
    if (ck) begin
      put(8'h00);
      q.push_back('{4, 0, 1'b1, ea, m, f});
    end
  endtask

  task automatic wait_q();
    for (k = 0; k < 3000 && q.size() > 0; k++) @(posedge clk_i);
    if (q.size() > 0) fail("notes left unmatched");
  endtask

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d failures", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Each completion pulse closes the timed instruction; the oldest note must match it.
  always @(negedge clk_i) begin
    if (rst_i) begin
      started = 0;
      cnt = 0;
    end else begin
      if (done === 1'b1) begin
        if (started && q.size() > 0 && (q[0].acks > 0) == (acks > 0)) begin
          n = q.pop_front();
          chk_n(cnt, n.st, "clock states");
          chk_n(acks, n.acks, "acknowledged fetches");
          if (n.ck) chk_v(acc, n.acc, "accumulator");
          if (n.ck) chk_v(flags & n.msk, n.flg, "flags");
        end
        started = 1;
        cnt = 0;
        acks = 0;
      end
      cnt++;
      if (sync === 1'b1 && ack === 1'b1) acks++;
    end
  end

  // Watchdog sized well beyond the program and the interrupt entry.
  initial begin
    #800000;
    fail("watchdog expired");
    complete_run();
  end

  // Program build, reset, program run, then interrupt entry.
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    irq_i = 1'b0;
    failures = 0;
    comparisons = 0;
    pc = 0;
    void'($urandom(98));
    for (k = 0; k < 4096; k++) bus.mem[k] = 8'h00;
    bus.vec[0] = 8'hCD;
    bus.vec[1] = 8'h00;
    bus.vec[2] = 8'h0C;
    a = 8'($urandom);
    b = 8'($urandom);
    d = 8'($urandom);
    p = 8'($urandom);
    w = {8'h08, 8'($urandom)};
    r1 = {a[6:0], a[7]};
    r2 = {r1[6:0], a[7]};
    s = {1'b0, r2} + {1'b0, b};
    h = {1'b0, r2[3:0]} + {1'b0, b[3:0]};
    s2 = {1'b0, s[7:0]} - {1'b0, d};
    put(8'h00);
    op(2, {8'h00, a, 8'h3E}, 7);
    op(1, 24'h000007, 4, 1'b1, r1, FC, mkf(a[7], 1'b0, 1'b0));
    op(1, 24'h000017, 4, 1'b1, r2, FC, mkf(r1[7], 1'b0, 1'b0));
    op(2, {8'h00, b, 8'hC6}, 7, 1'b1, s[7:0], FC | FH | FS, mkf(s[8], h[4], 1'b0));
    op(2, {8'h00, d, 8'hD6}, 7, 1'b1, s2[7:0], FC | FH | FS,
       mkf(s2[8], s[3:0] < d[3:0], 1'b1));
    op(2, 24'h00FFE6, 7, 1'b1, s2[7:0], FC | FH | FS, mkf(1'b0, s[3:0] < d[3:0], 1'b1));
    op(3, {w, 8'h32}, 13);
    op(2, 24'h00003E, 7);
    op(3, {w, 8'h3A}, 13, 1'b1, s2[7:0]);
    op(2, {8'h00, p, 8'hD3}, 10);
    op(2, {8'h00, p, 8'hDB}, 10, 1'b1, ~p);
    op(2, 24'h00153E, 7);
    op(2, 24'h0006D6, 7);
    op(1, 24'h000027, 4, 1'b1, 8'h09, FC | FH | FS, mkf(1'b0, 1'b0, 1'b1));
    lxp = pc + 1;
    op(3, 24'h000021, 10);
    op(3, 24'h090022, 16);
    op(3, 24'h09002A, 16);
    op(1, 24'h000009, 11);
    op(1, 24'h0000E9, 5);
    bus.mem[lxp] = pc[7:0];
    bus.mem[lxp + 1] = pc[15:8];
    op(1, 24'h000023, 5);
    op(1, 24'h000005, 5);
    op(1, 24'h0000C5, 11);
    op(1, 24'h0000E3, 17);
    op(3, {pc[15:0] + 16'h0003, 8'hC3}, 10);
    op(3, 24'h0000DA, 10);
    op(3, 24'h0000DC, 11);
    op(1, 24'h0000D8, 5);
    op(3, 24'h0A00D4, 17);
    bus.mem[12'hA00] = 8'hD0;
    op(0, 24'h000000, 11);
    op(1, 24'h0000FB, 4);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_q();
    $display("test program finished at %0t", $time);
    q.push_back('{17, 3, 1'b0, 8'h00, 8'h00, 8'h00});
    irq_i <= 1'b1;
    for (k = 0; k < 300 && ack !== 1'b1; k++) @(posedge clk_i);
    irq_i <= 1'b0;
    wait_q();
    $display("test interrupt finished at %0t", $time);
    complete_run();
  end
endmodule
